// [logic/dsr_regs.svh]
// Register offsets, field positions, reset values and timing counts of the status block
// What this block does
// RULE_01 - Gas alarm outputs and alarm state assert only after the alarm delay elapses.
// RULE_02 - Gas alarm state clears by itself once concentration no longer exceeds setpoint.
// RULE_03 - Sixteen-bit status word readable: high byte status one, low byte status two.
// RULE_04 - Status byte one: first-stage alarm in bit 1, second-stage in bit 0.
// RULE_05 - Internal failure raises trouble alarm, cleared automatically when failure goes away.
// RULE_06 - Byte one bits: 5 reduced flow, 4 flow too low, 3 heater, 2 sensor.
// RULE_07 - Reduced flow only indicates; flow too low also raises the trouble alarm.
// RULE_08 - Each local test switch press toggles test mode on or off; a press in the same cycle as a valid control write is dropped.
// RULE_09 - Writing 0x0001 to test control turns test mode on, 0x0000 turns it off.
// RULE_10 - Test mode ends by itself ten minutes after entry, however entered; a 0x0001 write in the timeout cycle keeps it on past the limit.
// RULE_11 - Test concentration register takes a binary percentage, accepted range 1 to 100.
// RULE_12 - Test mode state and test concentration readable at their readback registers.
// RULE_13 - Status byte two bit 2 shows test mode active.
// RULE_14 - In test mode gas alarm outputs behave as if the test gas were real.
// RULE_15 - Test timer restarts on every entry and stops whenever test mode is left.
// RULE_16 - Out-of-range concentration writes are ignored; the stored value is kept.
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

`define DSR_ADDR_TEST_MODE_RB 16'h9c51
`define DSR_ADDR_TEST_CONC_RB 16'h9c52
`define DSR_ADDR_TEST_MODE_CTL 16'h9c70
`define DSR_ADDR_TEST_CONC_SET 16'h9c71
`define DSR_ADDR_STATUS 16'h9e44

`define DSR_TEST_ON_VAL 16'h0001
`define DSR_TEST_OFF_VAL 16'h0000
`define DSR_CONC_MIN 16'h0001
`define DSR_CONC_MAX 16'h0064
`define DSR_TEST_CONC_RST 16'h0032

`define DSR_BIT_SECOND_ALARM 8
`define DSR_BIT_FIRST_ALARM 9
`define DSR_BIT_SENSOR 10
`define DSR_BIT_HEATER 11
`define DSR_BIT_FLOW_LOW 12
`define DSR_BIT_FLOW_RED 13
`define DSR_BIT_TEST 2

`define DSR_CLK_HZ 64'd125000000
`define DSR_TEST_TIMEOUT_MIN 64'd10
`define DSR_TEST_TIMEOUT_CYC (`DSR_TEST_TIMEOUT_MIN * 64'd60 * `DSR_CLK_HZ)

`endif

// [logic/dsr_pkg.sv]
// Types shared by the status block modules
package dsr_pkg;

  typedef enum logic [1:0] {
    DSR_ST_NORMAL = 2'h0,
    DSR_ST_DELAY = 2'h1,
    DSR_ST_ALARM = 2'h3
  } dsr_alarm_st_t;

endpackage : dsr_pkg

// [logic/dsr_alarm_stage.sv]
// One gas alarm stage qualified by the alarm delay
`timescale 1ns/10ps
module dsr_alarm_stage #(
  parameter int LW = 16,
  parameter int DW = 32
) (
  input logic clock,
  input logic rst_n,
  input logic [LW-1:0] level,
  input logic [LW-1:0] setpoint,
  input logic [DW-1:0] delay_cyc,
  output logic alarm
);
  import dsr_pkg::*;

  typedef struct packed {
    dsr_alarm_st_t st;
    logic [DW-1:0] cnt;
  } dsr_stage_t;

  dsr_stage_t s_q;
  dsr_stage_t s_d;
  logic exceed;

  assign exceed = level > setpoint;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      DSR_ST_NORMAL:
      begin
        if (exceed)
        begin
          s_d.st = DSR_ST_DELAY;
          s_d.cnt = '0;
        end
      end
      DSR_ST_DELAY:
      begin
        if (!exceed)
          s_d.st = DSR_ST_NORMAL; // RULE_02
        else if (s_q.cnt >= delay_cyc)
          s_d.st = DSR_ST_ALARM; // RULE_01
        else
          s_d.cnt = s_q.cnt + 1'b1;
      end
      DSR_ST_ALARM:
      begin
        // Self-resetting: no command is needed to leave the alarm
        if (!exceed)
          s_d.st = DSR_ST_NORMAL; // RULE_02
      end
      default:
        s_d.st = DSR_ST_NORMAL;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign alarm = (s_q.st == DSR_ST_ALARM);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wait_done;
    (s_q.st == DSR_ST_DELAY) && exceed && (s_q.cnt >= delay_cyc);
  endsequence

  sequence s_first_exceed;
    (s_q.st == DSR_ST_NORMAL) && exceed;
  endsequence

  a_alarm_delay_done: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    s_wait_done |=> alarm)
    else $error("alarm not raised after delay");

  a_alarm_not_early: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    s_first_exceed |=> !alarm ##0 (s_q.st == DSR_ST_DELAY))
    else $error("alarm raised without delay");

  a_alarm_self_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
    (alarm && !exceed) |=> (s_q.st == DSR_ST_NORMAL))
    else $error("alarm did not clear");

endmodule : dsr_alarm_stage

// [logic/dsr_status_regs.sv]
// Status word, test mode control and trouble reporting of the gas detector
`timescale 1ns/10ps
`include "dsr_regs.svh"
module dsr_status_regs #(
  parameter logic [63:0] TEST_TIMEOUT_CYC = `DSR_TEST_TIMEOUT_CYC,
  parameter int DELAY_W = 32
) (
  input logic clock,
  input logic rst_n,
  input logic [15:0] reg_addr,
  input logic reg_wr,
  input logic [15:0] reg_wdata,
  input logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  input logic [15:0] gas_conc,
  input logic [15:0] alarm_setpoint_1,
  input logic [15:0] alarm_setpoint_2,
  input logic [DELAY_W-1:0] alarm_delay_cyc,
  input logic test_switch_pin,
  input logic flow_reduced_pin,
  input logic flow_too_low_pin,
  input logic heater_broken_pin,
  input logic sensor_fault_pin,
  output logic first_stage_alarm,
  output logic second_stage_alarm,
  output logic trouble_alarm,
  output logic test_mode_active
);
  import dsr_pkg::*;

  localparam int TW = $clog2(TEST_TIMEOUT_CYC + 64'd1);
  localparam logic [TW-1:0] TEST_LAST = TW'(TEST_TIMEOUT_CYC - 64'd1);

  // Pin order: 0 sensor, 1 heater, 2 flow too low, 3 reduced flow
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic test_on;
    logic [TW-1:0] test_cnt;
    logic [15:0] test_conc;
    logic [1:0] al_out;
    logic trouble;
    logic [15:0] rdata;
    logic rvalid;
    logic err;
  } dsr_state_t;

  dsr_state_t st_q;
  dsr_state_t st_d;
  logic [4:0] pins;
  logic [1:0] stage_al;
  logic [15:0] stage_level;
  logic [15:0] setpoints [2];
  logic press;
  logic wr_ctl;
  logic wr_ctl_valid;
  logic wr_set;
  logic wr_set_valid;
  logic timeout;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == `DSR_ADDR_TEST_MODE_RB) || (a == `DSR_ADDR_TEST_CONC_RB) ||
                (a == `DSR_ADDR_TEST_MODE_CTL) || (a == `DSR_ADDR_TEST_CONC_SET) ||
                (a == `DSR_ADDR_STATUS);
  endfunction : is_mapped

  function automatic logic is_writable(input logic [15:0] a);
    is_writable = (a == `DSR_ADDR_TEST_MODE_CTL) || (a == `DSR_ADDR_TEST_CONC_SET);
  endfunction : is_writable

  function automatic logic [15:0] status_word(input dsr_state_t s);
    status_word = '0;
    status_word[`DSR_BIT_FIRST_ALARM] = s.al_out[0]; // RULE_04
    status_word[`DSR_BIT_SECOND_ALARM] = s.al_out[1]; // RULE_04
    status_word[`DSR_BIT_SENSOR] = s.lvl[0]; // RULE_06
    status_word[`DSR_BIT_HEATER] = s.lvl[1]; // RULE_06
    status_word[`DSR_BIT_FLOW_LOW] = s.lvl[2]; // RULE_06
    status_word[`DSR_BIT_FLOW_RED] = s.lvl[3]; // RULE_06
    status_word[`DSR_BIT_TEST] = s.test_on; // RULE_13
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////////
  assign pins = {test_switch_pin, flow_reduced_pin, flow_too_low_pin, heater_broken_pin,
                 sensor_fault_pin};
  // Test gas replaces the measured gas, so the real delay still applies in test
  assign stage_level = st_q.test_on ? st_q.test_conc : gas_conc; // RULE_14
  assign setpoints[0] = alarm_setpoint_1;
  assign setpoints[1] = alarm_setpoint_2;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_stage
      dsr_alarm_stage #(
        .LW(16),
        .DW(DELAY_W)
      ) u_stage (
        .clock(clock),
        .rst_n(rst_n),
        .level(stage_level),
        .setpoint(setpoints[g]),
        .delay_cyc(alarm_delay_cyc),
        .alarm(stage_al[g])
      );
    end
  endgenerate

  // Taken from the synchroniser, not st_d, so no loop runs through the next-state logic
  assign press = (st_q.s2[4] == st_q.s3[4]) && st_q.s3[4] && !st_q.lvl[4];
  assign wr_ctl = reg_wr && (reg_addr == `DSR_ADDR_TEST_MODE_CTL);
  assign wr_ctl_valid = wr_ctl &&
                        ((reg_wdata == `DSR_TEST_ON_VAL) || (reg_wdata == `DSR_TEST_OFF_VAL));
  assign wr_set = reg_wr && (reg_addr == `DSR_ADDR_TEST_CONC_SET);
  assign wr_set_valid = wr_set && (reg_wdata >= `DSR_CONC_MIN) && (reg_wdata <= `DSR_CONC_MAX);
  assign timeout = st_q.test_on && (st_q.test_cnt == TEST_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    // Three-stage sync; a level is taken only once stages two and three agree
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 5; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
        st_d.lvl[i] = st_q.s3[i];
    end

    // Priority: master write, then timeout, then switch press
    if (wr_ctl_valid)
      st_d.test_on = (reg_wdata == `DSR_TEST_ON_VAL); // RULE_09
    else if (timeout)
      st_d.test_on = 1'b0; // RULE_10
    else if (press)
      st_d.test_on = !st_q.test_on; // RULE_08

    if (!st_d.test_on)
      st_d.test_cnt = '0; // RULE_15
    else if (!st_q.test_on)
      st_d.test_cnt = '0; // RULE_15
    else
      st_d.test_cnt = st_q.test_cnt + 1'b1; // RULE_10

    if (wr_set_valid)
      st_d.test_conc = reg_wdata; // RULE_11 RULE_16

    st_d.al_out = stage_al; // RULE_01 RULE_14
    // Reduced flow is only reported, never a trouble alarm
    st_d.trouble = st_q.lvl[0] || st_q.lvl[1] || st_q.lvl[2]; // RULE_05 RULE_07

    st_d.rvalid = reg_rd;
    st_d.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `DSR_ADDR_STATUS: st_d.rdata = status_word(st_q); // RULE_03
        `DSR_ADDR_TEST_MODE_RB: st_d.rdata = {15'h0000, st_q.test_on}; // RULE_12
        `DSR_ADDR_TEST_MODE_CTL: st_d.rdata = {15'h0000, st_q.test_on};
        `DSR_ADDR_TEST_CONC_RB: st_d.rdata = st_q.test_conc; // RULE_12
        `DSR_ADDR_TEST_CONC_SET: st_d.rdata = st_q.test_conc;
        default: st_d.rdata = '0;
      endcase
    end
    st_d.err = (reg_rd && !is_mapped(reg_addr)) || (reg_wr && !is_writable(reg_addr));
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.test_conc <= `DSR_TEST_CONC_RST;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign reg_err = st_q.err;
  assign first_stage_alarm = st_q.al_out[0];
  assign second_stage_alarm = st_q.al_out[1];
  assign trouble_alarm = st_q.trouble;
  assign test_mode_active = st_q.test_on;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_status_read;
    reg_rd && (reg_addr == `DSR_ADDR_STATUS);
  endsequence

  a_status_alarm_bits: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
    s_status_read |=> reg_rvalid &&
      (reg_rdata[9:8] == {$past(st_q.al_out[0]), $past(st_q.al_out[1])}))
    else $error("status alarm bits wrong");

  a_status_test_bit: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
    s_status_read |=> reg_rdata[2] == $past(st_q.test_on))
    else $error("status test bit wrong");

  a_test_write_on: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    (wr_ctl && reg_wdata == 16'h0001) |=> test_mode_active && (st_q.test_cnt == '0 ||
      $past(st_q.test_on)))
    else $error("test mode not entered on write");

  a_test_write_off: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    (wr_ctl && reg_wdata == 16'h0000) |=> !test_mode_active && st_q.test_cnt == '0)
    else $error("test mode not left on write");

  a_test_timeout: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    (timeout && !wr_ctl_valid) |=> !test_mode_active)
    else $error("test mode did not time out");

  a_timer_restart: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
    $rose(st_q.test_on) |-> st_q.test_cnt == '0)
    else $error("test timer not restarted");

  a_switch_toggle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    (press && !wr_ctl_valid && !timeout) |=> test_mode_active != $past(test_mode_active))
    else $error("switch press did not toggle");

  a_conc_range: assert property (@(posedge clock) disable iff (!rst_n) // RULE_16
    (wr_set && (reg_wdata == 16'h0000 || reg_wdata > 16'h0064)) |=> $stable(st_q.test_conc))
    else $error("out of range concentration stored");

  a_trouble_flags: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    (st_q.lvl[3] && !st_q.lvl[2] && !st_q.lvl[1] && !st_q.lvl[0]) |=> !trouble_alarm)
    else $error("reduced flow raised trouble");

  a_status_trouble_bits: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    s_status_read |=> reg_rdata[13:10] == $past(st_q.lvl[3:0]))
    else $error("status trouble bits wrong");

  a_status_zero_bits: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    s_status_read |=> (reg_rdata[15:14] == 2'h0) && (reg_rdata[7:3] == 5'h00) &&
      (reg_rdata[1:0] == 2'h0))
    else $error("status spare bits set");

  a_trouble_raise: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
    (st_q.lvl[2:0] != 3'h0) |=> trouble_alarm)
    else $error("trouble alarm not raised");

  a_trouble_clear: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
    (st_q.lvl[2:0] == 3'h0) |=> !trouble_alarm)
    else $error("trouble alarm not cleared");

  a_mode_readback: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    (reg_rd && reg_addr == `DSR_ADDR_TEST_MODE_RB) |=>
      reg_rdata == {15'h0000, $past(st_q.test_on)})
    else $error("test mode readback wrong");

  a_ctl_readback: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    (reg_rd && reg_addr == `DSR_ADDR_TEST_MODE_CTL) |=>
      reg_rdata == {15'h0000, $past(st_q.test_on)})
    else $error("test control readback wrong");

  a_conc_readback: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
    (reg_rd && reg_addr == `DSR_ADDR_TEST_CONC_RB) |=> reg_rdata == $past(st_q.test_conc))
    else $error("test concentration readback wrong");

  a_conc_accept: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    (wr_set && reg_wdata >= 16'h0001 && reg_wdata <= 16'h0064) |=>
      st_q.test_conc == $past(reg_wdata))
    else $error("valid concentration not stored");

  a_read_valid: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    reg_rd |=> reg_rvalid)
    else $error("read not answered");

  a_read_idle: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    !reg_rd |=> !reg_rvalid && (reg_rdata == 16'h0000))
    else $error("read data without request");

  a_status_write_err: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
    (reg_wr && reg_addr == `DSR_ADDR_STATUS) |=> reg_err)
    else $error("status write not refused");

  a_timer_count: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    (st_q.test_on && !timeout && !wr_ctl_valid && !press) |=>
      test_mode_active && (st_q.test_cnt == $past(st_q.test_cnt) + 1'b1))
    else $error("test timer did not advance");

  a_timer_stopped: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
    !st_q.test_on |-> st_q.test_cnt == '0)
    else $error("test timer runs while off");

  a_ctl_write_ignored: assert property (@(posedge clock) disable iff (!rst_n) // RULE_09
    (wr_ctl && !wr_ctl_valid && !timeout && !press) |=> $stable(test_mode_active))
    else $error("bad control value changed test mode");

  a_test_clear_first: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
    (st_q.test_on && st_q.test_conc <= alarm_setpoint_1) |=> !stage_al[0])
    else $error("first stage follows real gas in test");

  a_test_clear_second: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
    (st_q.test_on && st_q.test_conc <= alarm_setpoint_2) |=> !stage_al[1])
    else $error("second stage follows real gas in test");

endmodule : dsr_status_regs

// [verification/dsr_master_model.sv]
// Register master model that drives the status block's register port
`timescale 1ns/10ps
module dsr_master_model (
  input logic clock,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input logic [15:0] reg_rdata,
  input logic reg_rvalid,
  input logic reg_err
);
  initial
  begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Idle address and data are inverted so a stale value never looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] v, output logic e);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    e = reg_err;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    d = reg_rvalid ? reg_rdata : 16'hxxxx;
    e = reg_err;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : dsr_master_model

// [verification/detector_status_and_test_regs_tb.sv]
// Self-checking bench of the status and test register block
`timescale 1ns/10ps
`include "dsr_regs.svh"
module detector_status_and_test_regs_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] gas_conc = 16'h0000;
  logic [15:0] sp1 = 16'h000a;
  logic [15:0] sp2 = 16'h003c;
  logic [31:0] dly = 32'h2;
  logic sw = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, reg_rvalid, reg_err, alm_first, alm_second, trb, tma, e;
  logic [15:0] cv [7] = '{16'h0019, 16'h0000, 16'h0065, 16'h0064, 16'h0001, 16'hffff, 16'h0019};
  integer mismatches = 0, compares = 0, cycles = 0, seed = 32'h2a43, tm = 0, conc = 50, i;
  always #4 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  dsr_status_regs #(.TEST_TIMEOUT_CYC(64'd20)) dsr_status_regs_i (.clock(clock),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
    .gas_conc(gas_conc), .alarm_setpoint_1(sp1), .alarm_setpoint_2(sp2),
    .alarm_delay_cyc(dly), .test_switch_pin(sw), .flow_reduced_pin(flt[3]),
    .flow_too_low_pin(flt[2]), .heater_broken_pin(flt[1]), .sensor_fault_pin(flt[0]),
    .first_stage_alarm(alm_first), .second_stage_alarm(alm_second), .trouble_alarm(trb),
    .test_mode_active(tma));
  dsr_master_model dsr_master_model_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_err(reg_err));
  //////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic w(input integer n);
    repeat (n) @(negedge clock);
  endtask : w
  // Model of status word and outputs; alarms follow test gas while test mode is on
  task automatic cs;
    integer lvl;
    lvl = tm ? conc : int'(gas_conc);
    dsr_master_model_i.rd(`DSR_ADDR_STATUS, d, e);
    chk(d, {2'b00, flt, lvl > sp1, lvl > sp2, 5'h00, tm[0], 2'b00});
    chk({e, alm_first, alm_second, trb, tma}, {1'b0, lvl > sp1, lvl > sp2, |flt[2:0], tm[0]});
  endtask : cs
  task automatic press;
    sw = 1'b1;
    w(8);
    sw = 1'b0;
    tm = 1 - tm;
    w(8);
  endtask : press
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    w(8);
    rst_n = 1'b1;
    dsr_master_model_i.rd(`DSR_ADDR_TEST_CONC_RB, d, e);
    chk(d, 16'h0032);
    cs();
    dsr_master_model_i.rd(16'h9c53, d, e);
    chk({d[14:0], e}, 16'h0001);
    dsr_master_model_i.wr(`DSR_ADDR_STATUS, 16'hffff, e);
    chk({15'h0000, e}, 16'h0001);
    // Boundaries and out-of-range values both sides of the accepted span
    for (i = 0; i < 7; i++)
    begin
      dsr_master_model_i.wr(`DSR_ADDR_TEST_CONC_SET, cv[i], e);
      if (cv[i] >= 1 && cv[i] <= 100)
        conc = cv[i];
      dsr_master_model_i.rd(`DSR_ADDR_TEST_CONC_RB, d, e);
      chk(d, conc[15:0]);
      dsr_master_model_i.rd(`DSR_ADDR_TEST_CONC_SET, d, e);
      chk(d, conc[15:0]);
    end
    dsr_master_model_i.wr(`DSR_ADDR_TEST_MODE_CTL, 16'h0001, e);
    tm = 1;
    dsr_master_model_i.wr(`DSR_ADDR_TEST_MODE_CTL, 16'h0002, e);
    dsr_master_model_i.rd(`DSR_ADDR_TEST_MODE_RB, d, e);
    chk(d, 16'h0001);
    dsr_master_model_i.rd(`DSR_ADDR_TEST_MODE_CTL, d, e);
    chk(d, 16'h0001);
    w(6);
    cs();
    w(12);
    tm = 0;
    cs();
    dsr_master_model_i.wr(`DSR_ADDR_TEST_MODE_CTL, 16'h0001, e);
    dsr_master_model_i.wr(`DSR_ADDR_TEST_MODE_CTL, 16'h0000, e);
    chk({15'h0000, tma}, 16'h0000);
    dsr_master_model_i.wr(`DSR_ADDR_TEST_MODE_CTL, 16'h0001, e);
    w(15);
    chk({15'h0000, tma}, 16'h0001);
    w(10);
    chk({15'h0000, tma}, 16'h0000);
    press();
    cs();
    press();
    cs();
    press();
    w(20);
    tm = 0;
    cs();
    // Long delay shows the alarm is held back, then raised
    dly = 32'h6;
    gas_conc = 16'h0078;
    w(5);
    chk({14'h0000, alm_first, alm_second}, 16'h0000);
    w(8);
    cs();
    dly = 32'h2;
    for (i = 0; i < 12; i++)
    begin
      gas_conc = 16'($random(seed)) & 16'h007f;
      flt = 4'($random(seed));
      w(10);
      cs();
    end
    results();
  end
endmodule : detector_status_and_test_regs_tb
